// ---- logic/lec_control.sv ----
// Regulator enable control with AXI4-Lite register access and pad isolation
`timescale 1ns/1ps
// Summary of operation
// - Control register bits 31:2 read zero, ignore writes
// - Voltage select: 0 gives 1.3 V, 1 gives 1.05 V
// - USB enable resets to inverse of clock strap
// - USB enable 0 floats output, 1 regulates
// - Strap low keeps USB regulator always on
// - Any power-down bit kills analog and core regulators
// - Strap high: USB on needs enable, no power-down
// - Core power removed asserts isolation, outputs float
// - Isolation enables weak bus holders on pads
// - Isolation disables pad pull resistors
// - RTC, USB, analog pads excluded from isolation
// - Pads use active-low enable plus pull inhibit
// - Regulator power-down cleared by wake pin or alarm
// - Core regulator disabled by its enable pin forces supply good high
module lec_control (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   // AXI4-Lite slave
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Board straps and status
   input wire logic clockSelectStrap,
   input wire logic core_regulator_enable_n_pin,
   input wire logic wake_pin,
   input wire logic rtcAlarm,
   input wire logic corePowerPresent,
   input wire logic coreVoltageOk,
   input wire logic reset_n_pin,
   // Pad requests from the core logic
   input wire logic [lec_pkg::PAD_COUNT-1:0] padDriveReq,
   input wire logic [lec_pkg::PAD_COUNT-1:0] padPullReq,
   input wire logic [lec_pkg::PAD_COUNT-1:0] padExempt,
   // Results
   output lec_pkg::lec_reg_state_t regulatorState,
   output logic usb_regulator_output_pin_oe,
   output logic core_off_isolation,
   output logic supply_good,
   output logic hardwareReset_n,
   output lec_pkg::lec_pad_t padCtl
);
   import lec_pkg::*;

   lec_state_t state;
   lec_state_t next_state;
   logic wrFire;
   logic rdFire;
   logic [15:0] rdAddr;

   // -------------------------------------------------------------
   // Regulator enable matrix
   // -------------------------------------------------------------
   logic anyPd;
   logic usbOn;
   always_comb begin
      anyPd = state.bandgapPowerDown | state.regulatorsPowerDown;
      // Strap low pins USB on regardless of power-down bits
      if (!clockSelectStrap) begin
         usbOn = 1'b1;
      end else begin
         usbOn = !anyPd && state.usbRegulatorEnable;
      end
   end

   // Outputs of the matrix; registered state feeds them directly
   assign regulatorState.analogOn = !anyPd;
   assign regulatorState.coreOn = !anyPd && !core_regulator_enable_n_pin;
   assign regulatorState.usbOn = usbOn;
   assign regulatorState.coreLow = state.coreVoltageSelect; // 1 selects 1.05 V
   // Disabled regulator leaves its output floating
   assign usb_regulator_output_pin_oe = usbOn;
   // Comparator is bypassed when the core regulator is off externally
   assign supply_good = core_regulator_enable_n_pin | coreVoltageOk;
   assign hardwareReset_n = reset_n_pin & supply_good;

   // -------------------------------------------------------------
   // Pad isolation
   // -------------------------------------------------------------
   assign core_off_isolation = !corePowerPresent;
   genvar g;
   generate
      for (g = 0; g < PAD_COUNT; g++) begin : gPad
         logic iso;
         assign iso = core_off_isolation && !padExempt[g];
         // Active-low enable; isolation forces strong driver off
         assign padCtl.outEnableN[g] = iso ? 1'b1 : !padDriveReq[g];
         assign padCtl.pullInhibit[g] = iso ? 1'b1 : !padPullReq[g];
         assign padCtl.holderEnable[g] = iso;
      end
   endgenerate

   // -------------------------------------------------------------
   // Bus slave and register state
   // -------------------------------------------------------------
   assign s_axi_awready = (state.bus == BUS_IDLE) && !state.awHeld;
   assign s_axi_wready = (state.bus == BUS_IDLE) && !state.wHeld;
   // Read held off while a write half is offered, so a taken read is never dropped
   assign s_axi_arready = (state.bus == BUS_IDLE) && !(state.awHeld || state.wHeld)
      && !s_axi_awvalid && !s_axi_wvalid;
   assign s_axi_bvalid = state.bus == BUS_WRESP;
   assign s_axi_rvalid = state.bus == BUS_RDATA;
   assign s_axi_bresp = state.resp;
   assign s_axi_rresp = state.resp;
   assign s_axi_rdata = state.rdata;

   logic [15:0] wAddr;
   logic [31:0] wData;
   logic wLane0;
   logic haveAw;
   logic haveW;
   always_comb begin
      next_state = state;
      haveAw = state.awHeld || (s_axi_awvalid && s_axi_awready);
      haveW = state.wHeld || (s_axi_wvalid && s_axi_wready);
      wAddr = state.awHeld ? state.awaddr : s_axi_awaddr;
      wData = state.wHeld ? state.wdata : s_axi_wdata;
      wLane0 = state.wHeld ? state.wstrb[0] : s_axi_wstrb[0];
      wrFire = (state.bus == BUS_IDLE) && haveAw && haveW;
      rdFire = s_axi_arvalid && s_axi_arready;
      rdAddr = {s_axi_araddr[15:2], 2'b00};
      // Strap sampled once after reset release
      if (!state.strapTaken) begin
         next_state.strapTaken = 1'b1;
         next_state.usbRegulatorEnable = !clockSelectStrap;
      end
      unique case (state.bus)
         BUS_IDLE: begin
            if (s_axi_awvalid && s_axi_awready && !wrFire) begin
               next_state.awHeld = 1'b1;
               next_state.awaddr = s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready && !wrFire) begin
               next_state.wHeld = 1'b1;
               next_state.wdata = s_axi_wdata;
               next_state.wstrb = s_axi_wstrb;
            end
            if (wrFire) begin
               next_state.awHeld = 1'b0;
               next_state.wHeld = 1'b0;
               next_state.bus = BUS_WRESP;
               next_state.resp = RESP_OKAY;
               // Write lands on the handshake edge
               unique case ({wAddr[15:2], 2'b00})
                  REG_CONTROL_ADDR: begin
                     if (wLane0) begin
                        next_state.coreVoltageSelect = wData[CORE_VSEL_BIT];
                        // Clear attempt ignored while strap is low
                        next_state.usbRegulatorEnable =
                           wData[USB_EN_BIT] | !clockSelectStrap;
                     end
                  end
                  REG_RTC_PM_ADDR: begin
                     if (wLane0) begin
                        next_state.regulatorsPowerDown = wData[REGULATORS_POWER_DOWN_BIT];
                        next_state.bandgapPowerDown = wData[BANDGAP_POWER_DOWN_BIT];
                     end
                  end
                  REG_STATUS_ADDR: ;
                  default: next_state.resp = RESP_SLVERR;
               endcase
            end else if (rdFire) begin
               next_state.bus = BUS_RDATA;
               next_state.resp = RESP_OKAY;
               next_state.rdata = 32'h0000_0000; // upper bits read zero
               unique case (rdAddr)
                  REG_CONTROL_ADDR: begin
                     next_state.rdata[CORE_VSEL_BIT] = state.coreVoltageSelect;
                     next_state.rdata[USB_EN_BIT] = state.usbRegulatorEnable;
                  end
                  REG_RTC_PM_ADDR: begin
                     next_state.rdata[REGULATORS_POWER_DOWN_BIT] = state.regulatorsPowerDown;
                     next_state.rdata[BANDGAP_POWER_DOWN_BIT] = state.bandgapPowerDown;
                  end
                  REG_STATUS_ADDR: begin
                     next_state.rdata[3:0] = regulatorState;
                  end
                  default: next_state.resp = RESP_SLVERR;
               endcase
            end
         end
         BUS_WRESP: begin
            if (s_axi_bready) begin
               next_state.bus = BUS_IDLE;
            end
         end
         BUS_RDATA: begin
            if (s_axi_rready) begin
               next_state.bus = BUS_IDLE;
            end
         end
         default: next_state.bus = BUS_IDLE;
      endcase
      // Wake sources override software, taking precedence over a write
      if (wake_pin || rtcAlarm) begin
         next_state.regulatorsPowerDown = 1'b0;
      end
   end

   // State register; clock enable low freezes it, but synchronous reset still loads
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state <= '0;
         state.bus <= BUS_IDLE;
         state.coreVoltageSelect <= RESET_CORE_VSEL;
         state.bandgapPowerDown <= RESET_PD;
         state.regulatorsPowerDown <= RESET_PD;
      end else if (clkEn) begin
         state <= next_state;
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   // USB regulator pinned on by a low strap
   usb_strap_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !clockSelectStrap |-> regulatorState.usbOn) else $error("usb off with strap low");
   // Any power-down bit turns analog and core regulators off
   pd_kills_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (state.bandgapPowerDown || state.regulatorsPowerDown) |->
      !regulatorState.analogOn && !regulatorState.coreOn) else $error("regulator on in pd");
   // Strap high: USB needs its enable and no power-down
   usb_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
      clockSelectStrap |-> regulatorState.usbOn == (state.usbRegulatorEnable
      && !state.bandgapPowerDown && !state.regulatorsPowerDown)) else $error("usb gate");
   // Output pin floats whenever the USB regulator is off
   usb_float_a: assert property (@(posedge mclk) disable iff (!rst_n)
      usb_regulator_output_pin_oe == regulatorState.usbOn) else $error("usb pin drive");
   // Voltage select lands on the write edge
   vsel_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
      clkEn && wrFire && wLane0 && {wAddr[15:2], 2'b00} == REG_CONTROL_ADDR
      |=> regulatorState.coreLow == $past(wData[CORE_VSEL_BIT])) else $error("vsel");
   // Reserved upper bits never read back set
   upper_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
      s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0000000) else $error("upper bits");
   // First enabled edge after reset loads the inverted strap
   strap_reset_a: assert property (@(posedge mclk) disable iff (!rst_n)
      clkEn && !state.strapTaken |=> state.usbRegulatorEnable == !$past(clockSelectStrap))
      else $error("strap reset value");
   // Wake pin or alarm clears the regulator power-down bit
   wake_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
      clkEn && (wake_pin || rtcAlarm) |=> !state.regulatorsPowerDown) else $error("wake");
   // Power-down bit only moves by a write or a wake source
   pd_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !(clkEn && (wrFire || wake_pin || rtcAlarm)) |=> $stable(state.regulatorsPowerDown))
      else $error("pd moved");
   // Comparator bypassed when the core regulator is off externally
   supply_good_a: assert property (@(posedge mclk) disable iff (!rst_n)
      core_regulator_enable_n_pin |-> supply_good) else $error("supply good");
   // Hardware reset is the pin and supply good combined
   hw_reset_a: assert property (@(posedge mclk) disable iff (!rst_n)
      hardwareReset_n == (reset_n_pin && supply_good)) else $error("hardware reset");
   // Isolated pad: driver off, pull off, holder on
   iso_pad_a: assert property (@(posedge mclk) disable iff (!rst_n)
      core_off_isolation && !padExempt[0] |-> padCtl.outEnableN[0] && padCtl.pullInhibit[0]
      && padCtl.holderEnable[0]) else $error("pad isolation");
   // Isolation follows loss of core power
   iso_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
      core_off_isolation == !corePowerPresent) else $error("isolation level");
   // Core regulator on exactly when enabled and not powered down
   core_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
      regulatorState.coreOn == (!anyPd && !core_regulator_enable_n_pin)) else $error("core on");
   // Analog regulator on whenever no power-down bit is set
   analog_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !anyPd |-> regulatorState.analogOn) else $error("analog on");
   // Without isolation the pads follow the core's requests
   pad_pass_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !core_off_isolation |-> padCtl.outEnableN == ~padDriveReq
      && padCtl.pullInhibit == ~padPullReq && padCtl.holderEnable == '0) else $error("pad pass");
   // Exempt pad: driver follows its request, holder off
   exempt_pad_a: assert property (@(posedge mclk) disable iff (!rst_n)
      padExempt[0] |-> padCtl.outEnableN[0] == !padDriveReq[0]
      && !padCtl.holderEnable[0]) else $error("exempt pad");
   // A read is never taken in the cycle a write half is offered
   rd_guard_a: assert property (@(posedge mclk) disable iff (!rst_n)
      s_axi_arready |-> !s_axi_awvalid && !s_axi_wvalid) else $error("read beside write");
   // Write response stands until it is taken
   bvalid_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
endmodule

// ---- logic/lec_pkg.sv ----
// Package for the regulator enable control block: offsets, fields, resets, types
package lec_pkg;
   // Register byte addresses
   localparam logic [15:0] REG_CONTROL_ADDR = 16'h7004; // regulator_control
   localparam logic [15:0] REG_RTC_PM_ADDR = 16'h1930; // rtc_power_management
   localparam logic [15:0] REG_STATUS_ADDR = 16'h7008; // regulator state readback
   // Field positions
   localparam int USB_EN_BIT = 0;
   localparam int CORE_VSEL_BIT = 1;
   localparam int REGULATORS_POWER_DOWN_BIT = 1;
   localparam int BANDGAP_POWER_DOWN_BIT = 2;
   // Reset values
   localparam logic RESET_CORE_VSEL = 1'b0;
   localparam logic RESET_PD = 1'b0;
   // Pad count under isolation control
   localparam int PAD_COUNT = 8;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Bus handshake state
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WRESP = 3'b010,
      BUS_RDATA = 3'b100
   } lec_bus_t;

   // Regulator on/off states carried together
   typedef struct packed {
      logic analogOn;
      logic coreOn;
      logic usbOn;
      logic coreLow;
   } lec_reg_state_t;

   // Pad controls carried together
   typedef struct packed {
      logic [PAD_COUNT-1:0] outEnableN;
      logic [PAD_COUNT-1:0] pullInhibit;
      logic [PAD_COUNT-1:0] holderEnable;
   } lec_pad_t;

   // All registered state
   typedef struct packed {
      lec_bus_t bus;
      logic coreVoltageSelect;
      logic usbRegulatorEnable;
      logic bandgapPowerDown;
      logic regulatorsPowerDown;
      logic strapTaken;
      logic [31:0] rdata;
      logic [1:0] resp;
      logic [15:0] awaddr;
      logic awHeld;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wHeld;
   } lec_state_t;
endpackage

// ---- verif/lec_board.sv ----
// Board model: clock strap, core regulator enable pin and external reset source
`timescale 1ns/1ps
module lec_board (
   input wire logic mclk,
   input wire logic strapLevel,
   input wire logic enableLevelN,
   input wire logic suppliesValid,
   output logic clockSelectStrap,
   output logic core_regulator_enable_n_pin,
   output logic reset_n_pin
);
   // Straps are plain board levels set by the bench
   assign clockSelectStrap = strapLevel;
   assign core_regulator_enable_n_pin = enableLevelN;
   // Reset held low until the supplies are valid, released a cycle later
   always_ff @(posedge mclk) begin
      reset_n_pin <= suppliesValid;
   end
endmodule

// ---- verif/lec_control_tb.sv ----
// Self-checking bench for the regulator enable control block
`timescale 1ns/1ps
module lec_control_tb;
   import lec_pkg::*;
   logic mclk = 0, rst_n = 0, awvalid = 0, wvalid = 0, arvalid = 0;
   logic [15:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, d, v, w;
   logic awready, wready, bvalid, arready, rvalid, oe, iso, sg, hrn, strap, enN, rstPin;
   logic [1:0] bresp, rresp, r;
   logic strapLvl = 1, enLvl = 1, supOk = 0, wake = 0, alarm = 0, cpp = 1, cvOk = 1;
   logic usbEn, vsel, bg, ldo;
   logic en = 1;
   logic [7:0] drv = 0, pull = 0, exm = 0;
   lec_reg_state_t regState;
   lec_pad_t pad;
   int mismatches = 0, checks_done = 0, cycles = 0, seed = 32'hc0c1972d;

   lec_board i_lec_board (.mclk(mclk), .strapLevel(strapLvl), .enableLevelN(enLvl),
      .suppliesValid(supOk), .clockSelectStrap(strap), .core_regulator_enable_n_pin(enN),
      .reset_n_pin(rstPin));
   lec_control i_lec_control (.mclk(mclk), .rst_n(rst_n), .clkEn(en),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
      .clockSelectStrap(strap), .core_regulator_enable_n_pin(enN), .wake_pin(wake),
      .rtcAlarm(alarm), .corePowerPresent(cpp), .coreVoltageOk(cvOk), .reset_n_pin(rstPin),
      .padDriveReq(drv), .padPullReq(pull), .padExempt(exm), .regulatorState(regState),
      .usb_regulator_output_pin_oe(oe), .core_off_isolation(iso), .supply_good(sg),
      .hardwareReset_n(hrn), .padCtl(pad));

   // Clock and a watchdog that cuts a hang short
   always #2 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 8000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   // ----------------------------------------
   // Bus tasks and comparison
   // ----------------------------------------
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask

   // Ready is looked at before the edge so the take edge is known without a race
   task automatic wr(input logic [15:0] a, input logic [31:0] dd, output logic [1:0] rs);
      logic pa, pw;
      pa = 1;
      pw = 1;
      awaddr <= a;
      wdata <= dd;
      awvalid <= 1;
      wvalid <= 1;
      while (pa || pw) begin
         @(negedge mclk);
         if (awready) pa = 0;
         if (wready) pw = 0;
         @(posedge mclk);
         if (!pa) awvalid <= 0;
         if (!pw) wvalid <= 0;
      end
      do @(negedge mclk); while (!bvalid);
      rs = bresp;
      @(posedge mclk);
   endtask

   task automatic rd(input logic [15:0] a, output logic [31:0] dd, output logic [1:0] rs);
      araddr <= a;
      arvalid <= 1;
      do @(negedge mclk); while (!arready);
      @(posedge mclk);
      arvalid <= 0;
      do @(negedge mclk); while (!rvalid);
      dd = rdata;
      rs = rresp;
      @(posedge mclk);
   endtask

   // Strap is sampled just after release, so wait a few edges before traffic
   task automatic rst(input logic s);
      strapLvl <= s;
      rst_n <= 0;
      repeat (12) @(posedge mclk);
      rst_n <= 1;
      repeat (3) @(posedge mclk);
      {usbEn, vsel, bg, ldo} = {!s, 3'b000};
   endtask

   // Reference model of regulator states, pads and reset combining
   task automatic settle();
      lec_reg_state_t e;
      logic [7:0] m;
      @(posedge mclk);
      @(negedge mclk);
      e.analogOn = !(bg | ldo);
      e.coreOn = e.analogOn & !enLvl;
      e.usbOn = strapLvl ? (e.analogOn & usbEn) : 1'b1;
      e.coreLow = vsel;
      m = {8{!cpp}} & ~exm;
      chk("regState", 32'(regState), 32'(e));
      chk("usbOe", 32'(oe), 32'(e.usbOn));
      chk("supplyGood", 32'(sg), 32'(enLvl | cvOk));
      chk("hwReset", 32'(hrn), 32'(supOk & (enLvl | cvOk)));
      chk("isolation", 32'(iso), 32'(!cpp));
      chk("pads", 32'(pad), 32'({m | ~drv, m | ~pull, m}));
      @(posedge mclk);
      rd(REG_STATUS_ADDR, v, r);
      chk("status", v, 32'(e));
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Main sequence
   initial begin
      rst(1);
      supOk <= 1;
      rd(REG_CONTROL_ADDR, v, r);
      chk("ctlReset", v, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 20; i++) begin
         d = $random(seed);
         w = $random(seed);
         wr(REG_CONTROL_ADDR, d, r);
         chk("okResp", 32'(r), 32'(RESP_OKAY));
         {vsel, usbEn} = d[1:0];
         wr(REG_RTC_PM_ADDR, w, r);
         {bg, ldo} = w[2:1];
         rd(REG_CONTROL_ADDR, v, r);
         chk("ctlRead", v, {30'h0, vsel, usbEn});
         w = $random(seed);
         {enLvl, cvOk, cpp} <= w[2:0];
         {exm, pull, drv} <= w[31:8];
         settle();
      end
      $display("test random done");
      wr(16'h0100, 32'hFFFF_FFFF, r);
      chk("wrUnmapped", 32'(r), 32'(RESP_SLVERR));
      rd(16'h0100, v, r);
      chk("rdUnmapped", 32'(r), 32'(RESP_SLVERR));
      $display("test unmapped done");
      for (int k = 0; k < 2; k++) begin
         wr(REG_RTC_PM_ADDR, 32'h6, r);
         {alarm, wake} <= (k == 0) ? 2'b01 : 2'b10;
         @(posedge mclk);
         {alarm, wake} <= 2'b00;
         rd(REG_RTC_PM_ADDR, v, r);
         chk("wakeClear", 32'(v[2:1]), 32'h2);
      end
      {bg, ldo} = 2'b10;
      settle();
      $display("test wake done");
      // Clock enable low must freeze the power-down bit against a wake
      wr(REG_RTC_PM_ADDR, 32'h6, r);
      en <= 0;
      wake <= 1;
      repeat (3) @(posedge mclk);
      {en, wake} <= 2'b10;
      rd(REG_RTC_PM_ADDR, v, r);
      chk("frozen", 32'(v[2:1]), 32'h3);
      $display("test freeze done");
      rst(0);
      rd(REG_CONTROL_ADDR, v, r);
      chk("ctlStrapLow", v, 32'h1);
      wr(REG_CONTROL_ADDR, 32'h0, r);
      rd(REG_CONTROL_ADDR, v, r);
      chk("usbKept", v, 32'h1);
      wr(REG_RTC_PM_ADDR, 32'h6, r);
      {bg, ldo} = 2'b11;
      settle();
      $display("test strap low done");
      tally_and_finish();
   end
endmodule
